/* design/bcelr_pkg.sv */
// Constants for the bridge error/link and overflow header registers
//
// Overview of operation
// [RULE_01] With target-abort error enable clear, a received target abort sends no error message.
// [RULE_02] With it set and bridge error messaging enabled, each target abort sends one message.
// [RULE_03] The bridge error command register sits at 40h, resets to 00h, only bit 0 writable.
// [RULE_04] Link control bits 31:29 hold the lowest subordinate hub number, read/write.
// [RULE_05] Link control bits 27:25 hold the highest subordinate hub number, read/write.
// [RULE_06] Link control bits 15:14 give link width; only 00 (8 bit) is defined for software.
// [RULE_07] The overflow function is an extra header space alongside the host bridge function.
// [RULE_08] The overflow function returns a fixed 16-bit vendor code at 00h.
// [RULE_09] The overflow function returns a fixed 16-bit device code at 02h.
// [RULE_10] Subsystem vendor (2Ch) and subsystem code (2Eh) reset to 0000h and take one write.
// [RULE_11] Reserved bits and offsets read zero and ignore writes; reserved link control bits read their fixed pattern 0004_2802h instead.
package bcelr_pkg;
    // Register indices; each index equals the register's byte offset
    localparam logic [7:0] IDX_VENDOR = 8'h00;
    localparam logic [7:0] IDX_DEVICE = 8'h02;
    localparam logic [7:0] IDX_CMD6 = 8'h04;
    localparam logic [7:0] IDX_STS6 = 8'h06;
    localparam logic [7:0] IDX_REV = 8'h08;
    localparam logic [7:0] IDX_SUBC = 8'h0A;
    localparam logic [7:0] IDX_BASEC = 8'h0B;
    localparam logic [7:0] IDX_HDR = 8'h0E;
    localparam logic [7:0] IDX_BAR = 8'h10;
    localparam logic [7:0] IDX_SSVID = 8'h2C;
    localparam logic [7:0] IDX_SSID = 8'h2E;
    localparam logic [7:0] IDX_ERRCMD = 8'h40;
    localparam logic [7:0] IDX_LINK = 8'h50;
    localparam logic [7:0] IDX_BCMD = 8'h60;
    localparam logic [7:0] IDX_IRQ_STS = 8'h61;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h62;
    // Fixed identity values, arbitrary
    localparam logic [15:0] VENDOR_CODE = 16'h1A2B;
    localparam logic [15:0] DEVICE_CODE = 16'h3C4D;
    localparam logic [7:0] REVISION = 8'h01;
    // Reset and fixed values
    localparam logic [15:0] STS6_VAL = 16'h0080;
    localparam logic [7:0] SUBC_VAL = 8'h80;
    localparam logic [7:0] BASEC_VAL = 8'h08;
    localparam logic [7:0] HDR_VAL = 8'h00;
    localparam logic [31:0] BAR_VAL = 32'h0000_0000;
    localparam logic [15:0] WO_RST = 16'h0000;
    localparam logic [31:0] LINK_RST = 32'h0E04_2802;
    // Link control fields
    localparam int LINK_FIRST_LSB = 29;
    localparam int LINK_LAST_LSB = 25;
    localparam int LINK_WIDTH_LSB = 14;
    localparam logic [31:0] LINK_RW_MASK = 32'hEE00_C000;
    localparam logic [2:0] FIRST_RST = 3'h0;
    localparam logic [2:0] LAST_RST = 3'h7;
    localparam logic [1:0] WIDTH_8BIT = 2'h0;
    // Interrupt status bits
    localparam int IRQ_TA = 0;
    localparam int IRQ_SERR = 1;
    localparam int IRQ_W = 2;
endpackage

/* design/bcelr_wo_reg.sv */
// Write-once 16-bit identifier register
`timescale 1ns/1ps
module bcelr_wo_reg (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wr,
    input wire logic [15:0] wdata,
    input wire logic [1:0] be,
    output logic [15:0] value
);
    typedef struct packed {
        logic locked;
        logic [15:0] val;
    } bcelr_wo_s;

    bcelr_wo_s st_r;
    bcelr_wo_s st_nxt;

    always_comb begin
        st_nxt = st_r;
        // Any write, even a partial one, closes the register
        if (wr && !st_r.locked) begin // RULE_10
            st_nxt.locked = 1'b1;
            if (be[0]) begin
                st_nxt.val[7:0] = wdata[7:0];
            end
            if (be[1]) begin
                st_nxt.val[15:8] = wdata[15:8];
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '{locked: 1'b0, val: bcelr_pkg::WO_RST};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign value = st_r.val;

    a_wo_locked: assert property (@(posedge clk) disable iff (!rst_n) // RULE_10
        st_r.locked && wr |=> $stable(value))
        else $error("write-once register changed after lock");
endmodule

/* design/bcelr_top.sv */
// Avalon-MM register bank: bridge error command, link control, overflow header
//
// Decided for this implementation: the Avalon-MM register port.
`timescale 1ns/1ps
module bcelr_top (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic [7:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    input wire logic TA_RECEIVED,
    output logic SERR_MSG,
    output logic [2:0] LOWEST_SUB_HUB,
    output logic [2:0] HIGHEST_SUB_HUB,
    output logic [1:0] LINK_WIDTH,
    output logic [1:0] OVF_CMD_EN,
    output logic IRQ
);
    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
        logic ta_err_en;
        logic [1:0] cmd6;
        logic [2:0] sub_first;
        logic [2:0] sub_last;
        logic [1:0] width;
        logic serr_glob_en;
        logic [1:0] irq_sts;
        logic [1:0] irq_mask;
        logic serr;
    } bcelr_state_s;

    bcelr_state_s st_r;
    bcelr_state_s st_nxt;
    logic rst_meta_r;
    logic rst_n;
    logic req;
    logic wr_go;
    logic [15:0] ssvid;
    logic [15:0] ssid;
    logic [31:0] link_word;

    // Reset: asynchronous assert, synchronous release
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            rst_meta_r <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n <= rst_meta_r;
        end
    end

    // Byte-lane merge of a write into a word, limited to writable bits
    function automatic logic [31:0] bcelr_merge(
        input logic [31:0] old,
        input logic [31:0] wd,
        input logic [3:0] be,
        input logic [31:0] mask
    );
        logic [31:0] lanes;
        lanes = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        bcelr_merge = (old & ~(lanes & mask)) | (wd & lanes & mask);
    endfunction

    assign req = AVS_READ || AVS_WRITE;
    // First cycle captures read data, second releases the master
    assign AVS_WAITREQUEST = req && !st_r.ack;
    assign wr_go = AVS_WRITE && st_r.ack;

    // Reserved link bits read their fixed default pattern
    assign link_word = (bcelr_pkg::LINK_RST & ~bcelr_pkg::LINK_RW_MASK)
        | {st_r.sub_first, 1'b0, st_r.sub_last, 9'h0, st_r.width, 14'h0};

    // Overflow function subsystem identifiers
    bcelr_wo_reg u_ssvid (
        .clk(CLK),
        .rst_n(rst_n),
        .wr(wr_go && AVS_ADDRESS == bcelr_pkg::IDX_SSVID), // RULE_10
        .wdata(AVS_WRITEDATA[15:0]),
        .be(AVS_BYTEENABLE[1:0]),
        .value(ssvid)
    );

    bcelr_wo_reg u_ssid (
        .clk(CLK),
        .rst_n(rst_n),
        .wr(wr_go && AVS_ADDRESS == bcelr_pkg::IDX_SSID), // RULE_10
        .wdata(AVS_WRITEDATA[15:0]),
        .be(AVS_BYTEENABLE[1:0]),
        .value(ssid)
    );

    always_comb begin
        logic [31:0] w;
        w = 32'h0000_0000;
        st_nxt = st_r;
        st_nxt.ack = req && !st_r.ack;
        // Read path; unmapped indices read zero
        if (AVS_READ && !st_r.ack) begin
            unique case (AVS_ADDRESS)
                bcelr_pkg::IDX_VENDOR: w = {16'h0000, bcelr_pkg::VENDOR_CODE}; // RULE_08
                bcelr_pkg::IDX_DEVICE: w = {16'h0000, bcelr_pkg::DEVICE_CODE}; // RULE_09
                bcelr_pkg::IDX_CMD6: w = {30'h0, st_r.cmd6}; // RULE_07
                bcelr_pkg::IDX_STS6: w = {16'h0000, bcelr_pkg::STS6_VAL};
                bcelr_pkg::IDX_REV: w = {24'h00_0000, bcelr_pkg::REVISION};
                bcelr_pkg::IDX_SUBC: w = {24'h00_0000, bcelr_pkg::SUBC_VAL};
                bcelr_pkg::IDX_BASEC: w = {24'h00_0000, bcelr_pkg::BASEC_VAL};
                bcelr_pkg::IDX_HDR: w = {24'h00_0000, bcelr_pkg::HDR_VAL};
                bcelr_pkg::IDX_BAR: w = bcelr_pkg::BAR_VAL;
                bcelr_pkg::IDX_SSVID: w = {16'h0000, ssvid}; // RULE_10
                bcelr_pkg::IDX_SSID: w = {16'h0000, ssid}; // RULE_10
                bcelr_pkg::IDX_ERRCMD: w = {31'h0, st_r.ta_err_en}; // RULE_03
                bcelr_pkg::IDX_LINK: w = link_word;
                bcelr_pkg::IDX_BCMD: w = {31'h0, st_r.serr_glob_en};
                bcelr_pkg::IDX_IRQ_STS: w = {30'h0, st_r.irq_sts};
                bcelr_pkg::IDX_IRQ_MASK: w = {30'h0, st_r.irq_mask};
                default: w = 32'h0000_0000; // RULE_11
            endcase
            st_nxt.rdata = w;
        end
        // Write path at the edge that releases the master
        if (wr_go) begin
            unique case (AVS_ADDRESS)
                bcelr_pkg::IDX_CMD6: begin
                    if (AVS_BYTEENABLE[0]) begin
                        st_nxt.cmd6 = AVS_WRITEDATA[1:0];
                    end
                end
                bcelr_pkg::IDX_ERRCMD: begin
                    if (AVS_BYTEENABLE[0]) begin
                        st_nxt.ta_err_en = AVS_WRITEDATA[0]; // RULE_03
                    end
                end
                bcelr_pkg::IDX_LINK: begin
                    w = bcelr_merge(link_word, AVS_WRITEDATA, AVS_BYTEENABLE,
                        bcelr_pkg::LINK_RW_MASK);
                    st_nxt.sub_first = w[bcelr_pkg::LINK_FIRST_LSB +: 3]; // RULE_04
                    st_nxt.sub_last = w[bcelr_pkg::LINK_LAST_LSB +: 3]; // RULE_05
                    // Reserved width codes are stored as written
                    st_nxt.width = w[bcelr_pkg::LINK_WIDTH_LSB +: 2]; // RULE_06
                end
                bcelr_pkg::IDX_BCMD: begin
                    if (AVS_BYTEENABLE[0]) begin
                        st_nxt.serr_glob_en = AVS_WRITEDATA[0];
                    end
                end
                bcelr_pkg::IDX_IRQ_STS: begin
                    if (AVS_BYTEENABLE[0]) begin
                        st_nxt.irq_sts = st_r.irq_sts & ~AVS_WRITEDATA[1:0];
                    end
                end
                bcelr_pkg::IDX_IRQ_MASK: begin
                    if (AVS_BYTEENABLE[0]) begin
                        st_nxt.irq_mask = AVS_WRITEDATA[1:0];
                    end
                end
                default: begin
                    st_nxt.cmd6 = st_r.cmd6; // RULE_11
                end
            endcase
        end
        // Error message on target abort; gated by both enables
        st_nxt.serr = TA_RECEIVED && st_r.ta_err_en && st_r.serr_glob_en; // RULE_01 RULE_02
        // Events set after the clear so a same-cycle event is kept
        if (TA_RECEIVED) begin
            st_nxt.irq_sts[bcelr_pkg::IRQ_TA] = 1'b1;
        end
        if (st_r.serr) begin
            st_nxt.irq_sts[bcelr_pkg::IRQ_SERR] = 1'b1;
        end
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            st_r.ack <= 1'b0;
            st_r.rdata <= 32'h0000_0000;
            st_r.ta_err_en <= 1'b0; // RULE_03
            st_r.cmd6 <= 2'h0;
            st_r.sub_first <= bcelr_pkg::FIRST_RST;
            st_r.sub_last <= bcelr_pkg::LAST_RST;
            st_r.width <= bcelr_pkg::WIDTH_8BIT;
            st_r.serr_glob_en <= 1'b0;
            st_r.irq_sts <= 2'h0;
            st_r.irq_mask <= 2'h0;
            st_r.serr <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign AVS_READDATA = st_r.rdata;
    assign SERR_MSG = st_r.serr;
    assign LOWEST_SUB_HUB = st_r.sub_first;
    assign HIGHEST_SUB_HUB = st_r.sub_last;
    assign LINK_WIDTH = st_r.width;
    assign OVF_CMD_EN = st_r.cmd6;
    assign IRQ = |(st_r.irq_sts & st_r.irq_mask);

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!rst_n);

    sequence s_rd_taken(logic [7:0] idx);
        AVS_READ && !st_r.ack && AVS_ADDRESS == idx;
    endsequence

    sequence s_link_write;
        wr_go && AVS_ADDRESS == bcelr_pkg::IDX_LINK && AVS_BYTEENABLE[3];
    endsequence

    a_serr_blocked: assert property ( // RULE_01
        TA_RECEIVED && !st_r.ta_err_en |=> !SERR_MSG)
        else $error("error message sent while target-abort enable clear");

    a_serr_sent: assert property ( // RULE_02
        TA_RECEIVED && st_r.ta_err_en && st_r.serr_glob_en |=> SERR_MSG
            ##1 (st_r.irq_sts[bcelr_pkg::IRQ_SERR]
            && (IRQ || !st_r.irq_mask[bcelr_pkg::IRQ_SERR])))
        else $error("target abort not turned into an error message");

    a_errcmd_read: assert property ( // RULE_03
        s_rd_taken(bcelr_pkg::IDX_ERRCMD) |=> AVS_READDATA[31:1] == 31'h0
            && !AVS_WAITREQUEST)
        else $error("error command reserved bits not zero");

    a_first_field: assert property ( // RULE_04
        s_link_write |=> LOWEST_SUB_HUB == $past(AVS_WRITEDATA[31:29]))
        else $error("lowest subordinate hub not written");

    a_last_field: assert property ( // RULE_05
        s_link_write |=> HIGHEST_SUB_HUB == $past(AVS_WRITEDATA[27:25]))
        else $error("highest subordinate hub not written");

    a_link_read: assert property ( // RULE_06
        s_rd_taken(bcelr_pkg::IDX_LINK) |=> AVS_READDATA[15:14] == LINK_WIDTH
            && AVS_READDATA[13:0] == bcelr_pkg::LINK_RST[13:0])
        else $error("link control readback wrong");

    a_vendor_read: assert property ( // RULE_08
        s_rd_taken(bcelr_pkg::IDX_VENDOR) |=> AVS_READDATA == {16'h0000,
            bcelr_pkg::VENDOR_CODE})
        else $error("vendor code readback wrong");

    a_device_read: assert property ( // RULE_09
        s_rd_taken(bcelr_pkg::IDX_DEVICE) |=> AVS_READDATA == {16'h0000,
            bcelr_pkg::DEVICE_CODE})
        else $error("device code readback wrong");

    a_unmapped_zero: assert property ( // RULE_11
        s_rd_taken(8'h14) |=> AVS_READDATA == 32'h0000_0000)
        else $error("reserved offset did not read zero");

    a_bus_two_cycle: assert property (
        req && AVS_WAITREQUEST ##1 req |-> !AVS_WAITREQUEST)
        else $error("waitrequest held beyond one cycle");
endmodule

/* sim/bcelr_hub_model.sv */
// Downstream hub model: raises target aborts and counts error messages
`timescale 1ns/1ps
module bcelr_hub_model (
    input wire logic clk,
    input wire logic rst_n,
    output logic ta_received,
    input wire logic serr_msg
);
    int serr_cnt = 0;
    int stray_cnt = 0;
    logic ta_q = 1'b0;
    initial ta_received = 1'b0;
    // A message must follow an abort by exactly one cycle
    always @(posedge clk) begin
        ta_q <= ta_received;
        if (rst_n === 1'b1 && serr_msg === 1'b1) begin
            serr_cnt <= serr_cnt + 1;
            if (ta_q !== 1'b1) stray_cnt <= stray_cnt + 1;
        end
    end
    // Back-to-back aborts, one per edge
    task automatic send_ta(input int n);
        @(posedge clk);
        ta_received <= 1'b1;
        repeat (n) @(posedge clk);
        ta_received <= 1'b0;
    endtask
endmodule

/* sim/tb.sv */
// Self-checking bench for the bridge error, link control and overflow header bank
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin fail_count++; \
    $display("[ERR] %s expected %h seen %h", nm, exp, got); end end
module tb;
    logic clk, rst_n, rd, wrq, ta, serr, wreq, irq;
    logic [7:0] addr;
    logic [31:0] wdata, rdata;
    logic [3:0] ben;
    logic [2:0] lowest, highest;
    logic [1:0] width, ovf_en;
    int fail_count = 0;
    int checks_done = 0;
    bcelr_top uut (.CLK(clk), .RST_N(rst_n), .AVS_ADDRESS(addr), .AVS_READ(rd),
        .AVS_WRITE(wrq), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(ben),
        .AVS_READDATA(rdata), .AVS_WAITREQUEST(wreq), .TA_RECEIVED(ta),
        .SERR_MSG(serr), .LOWEST_SUB_HUB(lowest), .HIGHEST_SUB_HUB(highest),
        .LINK_WIDTH(width), .OVF_CMD_EN(ovf_en), .IRQ(irq));
    bcelr_hub_model hub (.clk(clk), .rst_n(rst_n), .ta_received(ta), .serr_msg(serr));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // Request held until the rising edge that samples waitrequest low
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] b, output logic [31:0] q);
        int i;
        @(posedge clk);
        rd <= ~w;
        wrq <= w;
        addr <= a;
        wdata <= d;
        ben <= b;
        for (i = 0; i < 20; i++) begin
            @(posedge clk);
            if (wreq === 1'b0) break;
        end
        if (i == 20) begin
            fail_count++;
            $display("[ERR] waitrequest expected 0 seen 1");
            finish_test();
        end
        // Read data taken at the same edge that sees waitrequest low
        q = rdata;
        rd <= 1'b0;
        wrq <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] b);
        logic [31:0] q;
        bus(1'b1, a, d, b, q);
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, 4'hF, q);
        `CHK("readdata", exp, q)
    endtask
    task automatic t_reset_values();
        rc(bcelr_pkg::IDX_VENDOR, {16'h0000, bcelr_pkg::VENDOR_CODE});
        rc(bcelr_pkg::IDX_DEVICE, {16'h0000, bcelr_pkg::DEVICE_CODE});
        rc(bcelr_pkg::IDX_CMD6, 32'h0);
        rc(bcelr_pkg::IDX_STS6, 32'h0000_0080);
        rc(bcelr_pkg::IDX_REV, {24'h00_0000, bcelr_pkg::REVISION});
        rc(bcelr_pkg::IDX_SUBC, 32'h80);
        rc(bcelr_pkg::IDX_BASEC, 32'h08);
        rc(bcelr_pkg::IDX_HDR, 32'h0);
        rc(bcelr_pkg::IDX_SSVID, 32'h0);
        rc(bcelr_pkg::IDX_SSID, 32'h0);
        rc(bcelr_pkg::IDX_ERRCMD, 32'h0);
        rc(bcelr_pkg::IDX_LINK, 32'h0E04_2802);
        `CHK("lowest", 3'h0, lowest)
        `CHK("highest", 3'h7, highest)
        `CHK("width", 2'h0, width)
    endtask
    task automatic t_regs();
        wr(bcelr_pkg::IDX_ERRCMD, 32'hFF, 4'hF);
        rc(bcelr_pkg::IDX_ERRCMD, 32'h01);
        wr(bcelr_pkg::IDX_ERRCMD, 32'hFE, 4'hF);
        rc(bcelr_pkg::IDX_ERRCMD, 32'h00);
        wr(bcelr_pkg::IDX_CMD6, 32'hFFFF, 4'hF);
        rc(bcelr_pkg::IDX_CMD6, 32'h3);
        // Software keeps width at the only defined code
        wr(bcelr_pkg::IDX_LINK, 32'hB4FF_3FFF, 4'hF);
        rc(bcelr_pkg::IDX_LINK, 32'hA404_2802);
        // Top lane disabled: subordinate fields must survive
        wr(bcelr_pkg::IDX_LINK, 32'h0, 4'h7);
        rc(bcelr_pkg::IDX_LINK, 32'hA404_2802);
        @(negedge clk);
        `CHK("lowest", 3'h5, lowest)
        `CHK("highest", 3'h2, highest)
        `CHK("width", 2'h0, width)
        `CHK("ovf_en", 2'h3, ovf_en)
    endtask
    task automatic t_once();
        wr(bcelr_pkg::IDX_SSVID, 32'h1234, 4'h3);
        wr(bcelr_pkg::IDX_SSVID, 32'h5678, 4'h3);
        rc(bcelr_pkg::IDX_SSVID, 32'h1234);
        wr(bcelr_pkg::IDX_SSID, 32'hABCD, 4'h1);
        wr(bcelr_pkg::IDX_SSID, 32'hEF00, 4'h2);
        rc(bcelr_pkg::IDX_SSID, 32'h00CD);
    endtask
    task automatic t_serr();
        wr(bcelr_pkg::IDX_IRQ_MASK, 32'h0, 4'hF);
        wr(bcelr_pkg::IDX_ERRCMD, 32'h1, 4'hF);
        hub.send_ta(1);
        repeat (3) @(posedge clk);
        `CHK("serr_cnt", 0, hub.serr_cnt)
        wr(bcelr_pkg::IDX_BCMD, 32'h1, 4'hF);
        wr(bcelr_pkg::IDX_ERRCMD, 32'h0, 4'hF);
        hub.send_ta(1);
        repeat (3) @(posedge clk);
        `CHK("serr_cnt", 0, hub.serr_cnt)
        wr(bcelr_pkg::IDX_ERRCMD, 32'h1, 4'hF);
        hub.send_ta(2);
        repeat (3) @(posedge clk);
        `CHK("serr_cnt", 2, hub.serr_cnt)
        `CHK("stray_cnt", 0, hub.stray_cnt)
        rc(bcelr_pkg::IDX_IRQ_STS, 32'h3);
        `CHK("irq", 1'b0, irq)
        wr(bcelr_pkg::IDX_IRQ_MASK, 32'h2, 4'hF);
        @(negedge clk);
        `CHK("irq", 1'b1, irq)
        wr(bcelr_pkg::IDX_IRQ_STS, 32'h3, 4'hF);
        rc(bcelr_pkg::IDX_IRQ_STS, 32'h0);
        `CHK("irq", 1'b0, irq)
    endtask
    task automatic t_unmapped();
        wr(8'h20, 32'hFFFF_FFFF, 4'hF);
        rc(8'h20, 32'h0);
        rc(8'h14, 32'h0);
        wr(bcelr_pkg::IDX_VENDOR, 32'hFFFF_FFFF, 4'hF);
        rc(bcelr_pkg::IDX_VENDOR, {16'h0000, bcelr_pkg::VENDOR_CODE});
        wr(bcelr_pkg::IDX_BAR, 32'hFFFF_FFFF, 4'hF);
        rc(bcelr_pkg::IDX_BAR, 32'h0);
        wr(bcelr_pkg::IDX_STS6, 32'hFFFF_FFFF, 4'hF);
        rc(bcelr_pkg::IDX_STS6, 32'h0000_0080);
    endtask
    initial begin
        rst_n = 1'b0;
        rd = 1'b0;
        wrq = 1'b0;
        addr = 8'h00;
        wdata = 32'h0;
        ben = 4'h0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        // Synchroniser needs two edges before the first request
        repeat (3) @(posedge clk);
        t_reset_values();
        t_regs();
        t_once();
        t_serr();
        t_unmapped();
        finish_test();
    end
endmodule
